//--- pkg/cafb_defines.svh
// Register offsets, field positions, reset values for the acceptance filter
`ifndef CAFB_DEFINES_SVH
`define CAFB_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the 8-bit register port)
// ----------------------------------------------------------------
`define CAFB_OFS_CONTROL 8'h00
`define CAFB_OFS_STATUS 8'h01
`define CAFB_OFS_FILTER_CTRL 8'h0B
`define CAFB_OFS_MISC 8'h0D
`define CAFB_OFS_RX_ERR 8'h0E
`define CAFB_OFS_TX_ERR 8'h0F
`define CAFB_OFS_CODE_LO 8'h10
`define CAFB_OFS_MASK_LO 8'h14
`define CAFB_OFS_MASK_HI 8'h17
`define CAFB_OFS_CODE_HI 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CAFB_BIT_INIT_REQ 0
`define CAFB_BIT_SLEEP_REQ 1
`define CAFB_BIT_RECOV_SEL 6
`define CAFB_BIT_INIT_ACK 0
`define CAFB_BIT_SLEEP_ACK 1
`define CAFB_BIT_BUSOFF 2
`define CAFB_BIT_HOLD 0
`define CAFB_ORG_LSB 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CAFB_RST_MASK 8'h00
`define CAFB_RST_CODE 8'h00
`define CAFB_RST_BYTE 8'h00

`endif

//--- pkg/cafb_pkg.sv
// Types shared by the acceptance filter and bus-off status block
package cafb_pkg;

  // Filter organization field encodings
  typedef enum logic [1:0] {
    CAFB_ORG_32 = 2'b00,
    CAFB_ORG_16 = 2'b01,
    CAFB_ORG_8 = 2'b10,
    CAFB_ORG_CLOSED = 2'b11
  } cafb_org_e;

  // Evaluation sequence states
  typedef enum logic [0:0] {
    CAFB_ST_IDLE = 1'b0,
    CAFB_ST_EVAL = 1'b1
  } cafb_state_e;

  // Received identifier bytes plus the extended-frame flag
  typedef struct packed {
    logic ext;
    logic [3:0][7:0] id;
  } cafb_frame_s;

  // Verdict on one frame
  typedef struct packed {
    logic accept;
    logic drop;
    logic [2:0] hit;
  } cafb_verdict_s;

endpackage

//--- hdl/cafb_top.sv
// Acceptance filter, bus-off hold flag and error counter view
`timescale 1ns/1ns
`include "cafb_defines.svh"
// How it works
// - Bus-off hold flag readable anytime; writing one clears it, zero ignored.
// - With recovery option set, entering bus-off sets flag and holds bus-off.
// - Host clears flag to request recovery; flag then reads zero.
// - Receive and transmit error counts readable in two registers; writes ignored.
// - Every frame lands in background buffer; accepted ones raise rx_accept, the rest rx_drop.
// - Code bytes compared bitwise with identifier bytes, then qualified by mask.
// - In 32-bit filters, extended frames use four code/mask pairs; standard frames use two.
// - Code and mask registers readable anytime, writable only in init mode.
// - Mask bank sits at offsets 0x14 to 0x17, all bits reset zero.
// - Organization selects 32, 16, 8-bit filters or closed, accepting nothing.
// - Cleared mask bit demands equality, set bit ignores; all must agree.
module cafb_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Protocol engine side
  input wire logic rx_valid,
  input wire cafb_pkg::cafb_frame_s rx_frame,
  input wire logic [7:0] rx_err_cnt,
  input wire logic [7:0] tx_err_cnt,
  input wire logic busoff_enter,
  // Mode and bus-off status
  output logic init_acknowledge,
  output logic sleep_acknowledge,
  output logic busoff_hold_flag,
  output logic busoff_recovery_req,
  // Receive indication
  output logic rx_accept,
  output logic rx_drop,
  output logic [2:0] rx_hit,
  output cafb_pkg::cafb_frame_s rx_buffer
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic init_request;
  logic sleep_request;
  logic busoff_recovery_select;
  logic [1:0] filter_organization;
  logic [7:0] acceptance_code [0:7];
  logic [7:0] acceptance_mask [0:3];
  logic [7:0] rx_err_q;
  logic [7:0] tx_err_q;
  logic init_mode;
  logic hold_write_clear;
  logic [7:0] byte_ok;
  logic [7:0] filt_hit;
  logic [2:0] first_hit;
  logic any_hit;
  cafb_pkg::cafb_state_e state;
  cafb_pkg::cafb_verdict_s next_verdict;

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  // Init mode needs both request and acknowledge
  assign init_mode = init_request & init_acknowledge;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_request <= 1'b1;
      sleep_request <= 1'b0;
      busoff_recovery_select <= 1'b0;
    end else if (reg_wr && reg_addr == `CAFB_OFS_CONTROL) begin
      init_request <= reg_wdata[`CAFB_BIT_INIT_REQ];
      sleep_request <= reg_wdata[`CAFB_BIT_SLEEP_REQ];
      busoff_recovery_select <= reg_wdata[`CAFB_BIT_RECOV_SEL];
    end
  end

  // Acknowledges follow their requests one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_acknowledge <= 1'b0;
      sleep_acknowledge <= 1'b0;
    end else begin
      init_acknowledge <= init_request;
      sleep_acknowledge <= sleep_request;
    end
  end

  // ----------------------------------------------------------------
  // Bus-off hold
  // ----------------------------------------------------------------
  // one clears
  assign hold_write_clear = reg_wr && reg_addr == `CAFB_OFS_MISC &&
                            reg_wdata[`CAFB_BIT_HOLD];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busoff_hold_flag <= 1'b0;
    end else if (busoff_enter && busoff_recovery_select) begin
      // Entry beats a clear in the same cycle so the event is kept
      busoff_hold_flag <= 1'b1;
    end else if (hold_write_clear) begin
      busoff_hold_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busoff_recovery_req <= 1'b0;
    end else begin
      busoff_recovery_req <= hold_write_clear & busoff_hold_flag &
                             ~(busoff_enter & busoff_recovery_select);
    end
  end

  // ----------------------------------------------------------------
  // Error counter view
  // ----------------------------------------------------------------
  // read-only copies
  // values are only stable in sleep or init, so no gating here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_err_q <= `CAFB_RST_BYTE;
      tx_err_q <= `CAFB_RST_BYTE;
    end else begin
      rx_err_q <= rx_err_cnt;
      tx_err_q <= tx_err_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Filter configuration registers
  // ----------------------------------------------------------------
  // init-only writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filter_organization <= cafb_pkg::CAFB_ORG_32;
    end else if (init_mode && reg_wr &&
                 reg_addr == `CAFB_OFS_FILTER_CTRL) begin
      filter_organization <= reg_wdata[`CAFB_ORG_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        acceptance_code[i] <= `CAFB_RST_CODE;
      end
    end else if (init_mode && reg_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_addr == `CAFB_OFS_CODE_LO + 8'(i)) begin
          acceptance_code[i] <= reg_wdata;
        end
        if (reg_addr == `CAFB_OFS_CODE_HI + 8'(i)) begin
          acceptance_code[i + 4] <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        acceptance_mask[i] <= `CAFB_RST_MASK;
      end
    end else if (init_mode && reg_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_addr == `CAFB_OFS_MASK_LO + 8'(i)) begin
          acceptance_mask[i] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Acceptance compare
  // ----------------------------------------------------------------
  // Byte i compares against the identifier byte its filter width needs
  always_comb begin
    logic [1:0] idx;
    logic [7:0] id_byte;
    byte_ok = 8'h00;
    idx = 2'b00;
    id_byte = 8'h00;
    for (int i = 0; i < 8; i++) begin
      case (filter_organization)
        cafb_pkg::CAFB_ORG_32: idx = 2'(i);
        cafb_pkg::CAFB_ORG_16: idx = {1'b0, 1'(i)};
        default: idx = 2'b00;
      endcase
      id_byte = rx_buffer.id[idx];
      byte_ok[i] = &(~(acceptance_code[i] ^ id_byte) | acceptance_mask[idx]);
    end
  end

  // Per-filter hits; lowest numbered filter has priority
  always_comb begin
    filt_hit = 8'h00;
    case (filter_organization)
      cafb_pkg::CAFB_ORG_32: begin
        for (int f = 0; f < 2; f++) begin
          if (rx_buffer.ext) begin
            filt_hit[f] = &byte_ok[f * 4 +: 4];
          end else begin
            filt_hit[f] = &byte_ok[f * 4 +: 2];
          end
        end
      end
      cafb_pkg::CAFB_ORG_16: begin
        for (int f = 0; f < 4; f++) begin
          filt_hit[f] = &byte_ok[f * 2 +: 2];
        end
      end
      cafb_pkg::CAFB_ORG_8: begin
        filt_hit = byte_ok;
      end
      default: begin
        filt_hit = 8'h00;
      end
    endcase
  end

  always_comb begin
    first_hit = 3'h0;
    for (int f = 7; f >= 0; f--) begin
      if (filt_hit[f]) begin
        first_hit = 3'(f);
      end
    end
  end

  assign any_hit = |filt_hit;

  always_comb begin
    next_verdict.accept = any_hit;
    next_verdict.drop = ~any_hit;
    next_verdict.hit = first_hit;
  end

  // ----------------------------------------------------------------
  // Background buffer and evaluation sequence
  // ----------------------------------------------------------------
  // every frame buffered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_buffer <= '0;
    end else if (rx_valid) begin
      // A dropped frame is simply overwritten here
      rx_buffer <= rx_frame;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= cafb_pkg::CAFB_ST_IDLE;
    end else begin
      case (state)
        cafb_pkg::CAFB_ST_IDLE: begin
          if (rx_valid) begin
            state <= cafb_pkg::CAFB_ST_EVAL;
          end
        end
        cafb_pkg::CAFB_ST_EVAL: begin
          // Back-to-back frames stay in evaluation
          if (!rx_valid) begin
            state <= cafb_pkg::CAFB_ST_IDLE;
          end
        end
        default: begin
          state <= cafb_pkg::CAFB_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_accept <= 1'b0;
      rx_drop <= 1'b0;
      rx_hit <= 3'h0;
    end else begin
      rx_accept <= 1'b0;
      rx_drop <= 1'b0;
      if (state == cafb_pkg::CAFB_ST_EVAL) begin
        rx_accept <= next_verdict.accept;
        rx_drop <= next_verdict.drop;
        // Hit index keeps the last accepted frame's filter
        if (next_verdict.accept) begin
          rx_hit <= next_verdict.hit;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Data stand only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `CAFB_RST_BYTE;
    end else if (!reg_rd) begin
      reg_rdata <= `CAFB_RST_BYTE;
    end else begin
      reg_rdata <= `CAFB_RST_BYTE;
      case (reg_addr)
        `CAFB_OFS_CONTROL: begin
          reg_rdata[`CAFB_BIT_INIT_REQ] <= init_request;
          reg_rdata[`CAFB_BIT_SLEEP_REQ] <= sleep_request;
          reg_rdata[`CAFB_BIT_RECOV_SEL] <= busoff_recovery_select;
        end
        `CAFB_OFS_STATUS: begin
          reg_rdata[`CAFB_BIT_INIT_ACK] <= init_acknowledge;
          reg_rdata[`CAFB_BIT_SLEEP_ACK] <= sleep_acknowledge;
          reg_rdata[`CAFB_BIT_BUSOFF] <= busoff_hold_flag;
        end
        `CAFB_OFS_FILTER_CTRL: begin
          reg_rdata[`CAFB_ORG_LSB +: 2] <= filter_organization;
          reg_rdata[2:0] <= rx_hit;
        end
        `CAFB_OFS_MISC: begin
          reg_rdata[`CAFB_BIT_HOLD] <= busoff_hold_flag;
        end
        `CAFB_OFS_RX_ERR: begin
          reg_rdata <= rx_err_q;
        end
        `CAFB_OFS_TX_ERR: begin
          reg_rdata <= tx_err_q;
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (reg_addr == `CAFB_OFS_CODE_LO + 8'(i)) begin
              reg_rdata <= acceptance_code[i];
            end
            if (reg_addr == `CAFB_OFS_CODE_HI + 8'(i)) begin
              reg_rdata <= acceptance_code[i + 4];
            end
            if (reg_addr == `CAFB_OFS_MASK_LO + 8'(i)) begin
              reg_rdata <= acceptance_mask[i];
            end
          end
        end
      endcase
    end
  end

endmodule

//--- tb/cafb_monitor.sv
// Port checker for the acceptance filter and bus-off status block
`timescale 1ns/1ns
`include "cafb_defines.svh"
module cafb_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Protocol engine side
  input wire logic rx_valid,
  input wire cafb_pkg::cafb_frame_s rx_frame,
  input wire logic [7:0] rx_err_cnt,
  input wire logic [7:0] tx_err_cnt,
  input wire logic busoff_enter,
  // Status and receive indication
  input wire logic init_acknowledge,
  input wire logic sleep_acknowledge,
  input wire logic busoff_hold_flag,
  input wire logic busoff_recovery_req,
  input wire logic rx_accept,
  input wire logic rx_drop,
  input wire logic [2:0] rx_hit,
  input wire cafb_pkg::cafb_frame_s rx_buffer
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // read slot only
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  err_view_a: assert property (
    reg_rd && reg_addr == `CAFB_OFS_RX_ERR |=>
    reg_rdata == $past(rx_err_cnt, 2))
    else $error("rx error count read wrong");
  zero_write_a: assert property (
    reg_wr && reg_addr == `CAFB_OFS_MISC && !reg_wdata[0] && busoff_hold_flag
    |=> busoff_hold_flag) else $error("hold flag lost on zero write");
  hold_clear_a: assert property (
    reg_wr && reg_addr == `CAFB_OFS_MISC && reg_wdata[0] && busoff_hold_flag
    && !busoff_enter |=> !busoff_hold_flag && busoff_recovery_req)
    else $error("hold flag clear failed");
  recov_pulse_a: assert property (
    busoff_recovery_req |-> $fell(busoff_hold_flag) ##1 !busoff_recovery_req)
    else $error("bad recovery pulse");
  hold_cause_a: assert property (
    $rose(busoff_hold_flag) |-> $past(busoff_enter))
    else $error("hold flag set without bus-off");
  verdict_time_a: assert property (
    rx_valid |-> ##2 (rx_accept != rx_drop)) else $error("no verdict");
  verdict_cause_a: assert property (
    rx_accept || rx_drop |-> $past(rx_valid, 2)) else $error("stray verdict");
  buffer_copy_a: assert property (
    rx_valid |=> rx_buffer == $past(rx_frame)) else $error("buffer wrong");
  cover property (rx_accept);
  cover property (rx_drop);
  cover property (busoff_recovery_req);
endmodule

//--- tb/cafb_engine_model.sv
// Stand-in for the protocol engine: frames, error counts, bus-off
`timescale 1ns/1ns
module cafb_engine_model #(
  // Arbitrary counts, held steady so every read has one right answer
  parameter logic [7:0] RX_CNT = 8'h00,
  parameter logic [7:0] TX_CNT = 8'h00
) (
  // Clock
  input wire logic clk,
  // Engine outputs
  output logic rx_valid,
  output cafb_pkg::cafb_frame_s rx_frame,
  output logic [7:0] rx_err_cnt,
  output logic [7:0] tx_err_cnt,
  output logic busoff_enter
);
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    busoff_enter = 1'b0;
    rx_err_cnt = RX_CNT;
    tx_err_cnt = TX_CNT;
  end
  task automatic send(input cafb_pkg::cafb_frame_s f);
    @(posedge clk);
    rx_frame <= f;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    // Released lines show the inverse, never a stale copy
    rx_frame <= ~f;
  endtask
  task automatic busoff();
    @(posedge clk);
    busoff_enter <= 1'b1;
    @(posedge clk);
    busoff_enter <= 1'b0;
  endtask
endmodule

//--- tb/test_can_acceptance_filter_busoff_status.sv
// Self-checking bench for the acceptance filter and bus-off status block
`timescale 1ns/1ns
`include "cafb_defines.svh"
module test_can_acceptance_filter_busoff_status;
  localparam logic [7:0] RX_CNT = 8'h5a;
  localparam logic [7:0] TX_CNT = 8'ha5;
  localparam logic [7:0] CODE [8] = '{8'h11, 8'h22, 8'h33, 8'h44,
                                      8'h55, 8'h66, 8'h77, 8'h88};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rx_err_cnt, tx_err_cnt;
  logic rx_valid, busoff_enter, init_acknowledge, sleep_acknowledge;
  logic busoff_hold_flag, busoff_recovery_req, rx_accept, rx_drop;
  logic [2:0] rx_hit;
  cafb_pkg::cafb_frame_s rx_frame, rx_buffer;
  int n_errors = 0;
  int samples_checked = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  cafb_top dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .rx_err_cnt(rx_err_cnt), .tx_err_cnt(tx_err_cnt),
    .busoff_enter(busoff_enter), .init_acknowledge(init_acknowledge),
    .sleep_acknowledge(sleep_acknowledge),
    .busoff_hold_flag(busoff_hold_flag),
    .busoff_recovery_req(busoff_recovery_req), .rx_accept(rx_accept),
    .rx_drop(rx_drop), .rx_hit(rx_hit), .rx_buffer(rx_buffer));
  cafb_engine_model #(.RX_CNT(RX_CNT), .TX_CNT(TX_CNT)) eng (.clk(clk),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_err_cnt(rx_err_cnt),
    .tx_err_cnt(tx_err_cnt), .busoff_enter(busoff_enter));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Identifier word is {id3, id2, id1, id0}
  task automatic frm(input logic ext, input logic [31:0] id,
                     input logic acc, input logic [2:0] hit);
    eng.send({ext, id});
    @(posedge clk);
    #1 chk({6'h00, rx_accept, rx_drop}, {6'h00, acc, ~acc});
    if (acc) chk({5'h00, rx_hit}, {5'h00, hit});
  endtask
  // Organization can only change inside init mode
  task automatic org(input logic [7:0] o);
    wr(`CAFB_OFS_CONTROL, 8'h01);
    wr(`CAFB_OFS_FILTER_CTRL, o);
    wr(`CAFB_OFS_CONTROL, 8'h00);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results;
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(`CAFB_OFS_MASK_LO + i), 8'h00);
    end
    rd(`CAFB_OFS_STATUS, 8'h01);
    rd(`CAFB_OFS_RX_ERR, RX_CNT);
    wr(`CAFB_OFS_RX_ERR, 8'h00);
    rd(`CAFB_OFS_RX_ERR, RX_CNT);
    wr(`CAFB_OFS_TX_ERR, 8'h00);
    rd(`CAFB_OFS_TX_ERR, TX_CNT);
    rd(8'h3f, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'(`CAFB_OFS_CODE_LO + i), CODE[i]);
      wr(8'(`CAFB_OFS_CODE_HI + i), CODE[i+4]);
    end
    wr(8'(`CAFB_OFS_MASK_LO + 1), 8'h07);
    rd(8'(`CAFB_OFS_MASK_LO + 1), 8'h07);
    rd(8'(`CAFB_OFS_CODE_HI + 3), 8'h88);
    wr(`CAFB_OFS_CONTROL, 8'h00);
    wr(8'(`CAFB_OFS_MASK_LO + 1), 8'hff);
    rd(8'(`CAFB_OFS_MASK_LO + 1), 8'h07);
    frm(1'b1, 32'h4433_2211, 1'b1, 3'd0);
    frm(1'b1, 32'h4433_2611, 1'b1, 3'd0);
    frm(1'b1, 32'h4533_2211, 1'b0, 3'd0);
    frm(1'b1, 32'h4433_2a11, 1'b0, 3'd0);
    frm(1'b0, 32'h0000_2211, 1'b1, 3'd0);
    frm(1'b1, 32'h8877_6655, 1'b1, 3'd1);
    org(8'h10);
    frm(1'b1, 32'h0000_6655, 1'b1, 3'd2);
    frm(1'b0, 32'h0000_6255, 1'b1, 3'd2);
    org(8'h20);
    frm(1'b1, 32'h0000_0088, 1'b1, 3'd7);
    org(8'h30);
    frm(1'b1, 32'h4433_2211, 1'b0, 3'd0);
    rd(`CAFB_OFS_FILTER_CTRL, 8'h37);
    wr(`CAFB_OFS_CONTROL, 8'h40);
    eng.busoff();
    rd(`CAFB_OFS_STATUS, 8'h04);
    wr(`CAFB_OFS_MISC, 8'h00);
    rd(`CAFB_OFS_MISC, 8'h01);
    wr(`CAFB_OFS_MISC, 8'h01);
    #1 chk({7'h00, busoff_recovery_req}, 8'h01);
    rd(`CAFB_OFS_MISC, 8'h00);
    wr(`CAFB_OFS_CONTROL, 8'h00);
    eng.busoff();
    rd(`CAFB_OFS_MISC, 8'h00);
    wr(`CAFB_OFS_CONTROL, 8'h02);
    rd(`CAFB_OFS_STATUS, 8'h02);
    rd(`CAFB_OFS_TX_ERR, TX_CNT);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(8'(`CAFB_OFS_MASK_LO + 1), 8'h00);
    results;
  end
endmodule

bind cafb_top cafb_monitor mon (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_frame(rx_frame),
  .rx_err_cnt(rx_err_cnt), .tx_err_cnt(tx_err_cnt),
  .busoff_enter(busoff_enter), .init_acknowledge(init_acknowledge),
  .sleep_acknowledge(sleep_acknowledge), .busoff_hold_flag(busoff_hold_flag),
  .busoff_recovery_req(busoff_recovery_req), .rx_accept(rx_accept),
  .rx_drop(rx_drop), .rx_hit(rx_hit), .rx_buffer(rx_buffer));
